/* i2chs_top.sv */
// two-wire slave and firmware bit master with its registers
`timescale 1ns/10ps
`include "i2chs_defs.svh"
module i2chs_top (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // special-function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_bit_wr,
    input  wire logic [2:0] sfr_bit_sel,
    input  wire logic       sfr_bit_val,
    output logic      [7:0] sfr_rdata,
    // shared interrupt
    input  wire logic       spi_flag,
    output logic            irq_req,
    output logic      [7:0] irq_vector,
    // dedicated pins
    input  wire logic       serial_data_pin_in,
    output logic            serial_data_pin_out,
    output logic            serial_data_pin_oe_n,
    input  wire logic       serial_clock_line_in,
    output logic            serial_clock_line_out,
    output logic            serial_clock_line_oe_n
);

    i2chs_pkg::i2chs_state_e state;
    localparam logic [7:0] rst_ctrl = `I2CHS_RST_CTRL;

    logic [1:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_q;
    logic       sda_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;

    logic       master_data_out_bit;
    logic       data_pin_output_enable;
    logic       master_clock_out_bit;
    logic       master_data_in_bit;
    logic       master_select_bit;
    logic       interface_reset_bit;
    logic       slave_direction_flag;
    logic       byte_done_flag;

    logic [7:0] slave_address_primary;
    logic [7:0] slave_address_secondary;
    logic [7:0] tx_byte;
    logic [7:0] ctrl_view;
    logic [7:0] next_ctrl;

    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [3:0] bit_cnt;
    logic       is_addr_byte;
    logic       host_acked;
    logic       access_done;

    logic       slave_on;
    logic       ctrl_hit;
    logic       data_access;
    logic       set_flag;
    logic       halt_req;
    logic       addr_match;

    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic       fifo_pop;
    logic [7:0] fifo_out_data;

    // address decode shared by every register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // replace one bit of a byte, for bit-addressable writes
    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] s, input logic b);
        logic [7:0] o;
        o    = v;
        o[s] = b;
        return o;
    endfunction

    // pins pass two flops before any logic sees them
    i2chs_sync #(
        .W (2)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({serial_clock_line_in, serial_data_pin_in}),
        .sync_out (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // previous synchronised levels for edge finding
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // clock edges and bus conditions
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
    assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

    // slave runs only when not master and not held in reset
    assign slave_on = ~master_select_bit & ~interface_reset_bit;

    // register strobes
    assign ctrl_hit    = hit(sfr_addr, `I2CHS_ADDR_CTRL);
    assign data_access = (sfr_rd | sfr_wr) & hit(sfr_addr, `I2CHS_ADDR_DATA);
    assign fifo_pop    = sfr_rd & hit(sfr_addr, `I2CHS_ADDR_DATA);

    // either address register may claim the transfer
    assign addr_match = (rx_shift[7:1] == slave_address_primary[6:0]) |
                        (rx_shift[7:1] == slave_address_secondary[6:0]);

    // a flag only follows an acknowledged byte
    assign set_flag = slave_on & scl_fall &
                      ((state == i2chs_pkg::st_ack) |
                       ((state == i2chs_pkg::st_txack) & host_acked));

    // second access without a fresh flag stops the controller
    assign halt_req = data_access & access_done & ~byte_done_flag & ~set_flag;

    assign fifo_in_valid = (state == i2chs_pkg::st_push);

    i2chs_fifo #(
        .W (8),
        .D (`I2CHS_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_shift),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // control byte after a byte or single-bit write
    assign ctrl_view = {master_data_out_bit, data_pin_output_enable, master_clock_out_bit,
                        master_data_in_bit, master_select_bit, interface_reset_bit,
                        slave_direction_flag, byte_done_flag};

    always_comb begin
        next_ctrl = ctrl_view;
        if (sfr_wr) begin
            next_ctrl = sfr_wdata;
        end else if (sfr_bit_wr) begin
            next_ctrl = put_bit(ctrl_view, sfr_bit_sel, sfr_bit_val);
        end
    end

    // firmware-owned control bits; hardware bits ignore writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            master_data_out_bit    <= rst_ctrl[`I2CHS_B_MDO];
            data_pin_output_enable <= rst_ctrl[`I2CHS_B_MDE];
            master_clock_out_bit   <= rst_ctrl[`I2CHS_B_MCO];
            master_select_bit      <= rst_ctrl[`I2CHS_B_MSEL];
            interface_reset_bit    <= rst_ctrl[`I2CHS_B_SRST];
        end else if (ctrl_hit && (sfr_wr || sfr_bit_wr)) begin
            master_data_out_bit    <= next_ctrl[`I2CHS_B_MDO];
            data_pin_output_enable <= next_ctrl[`I2CHS_B_MDE];
            master_clock_out_bit   <= next_ctrl[`I2CHS_B_MCO];
            master_select_bit      <= next_ctrl[`I2CHS_B_MSEL];
            interface_reset_bit    <= next_ctrl[`I2CHS_B_SRST];
        end
    end

    // master receive bit: sample the data pin on rising clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            master_data_in_bit <= rst_ctrl[`I2CHS_B_MDI];
        end else if (master_select_bit && !data_pin_output_enable && scl_rise) begin
            master_data_in_bit <= sda_s;
        end
    end

    // address registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_address_primary   <= `I2CHS_RST_SAP;
            slave_address_secondary <= `I2CHS_RST_SAS;
        end else if (sfr_wr) begin
            if (hit(sfr_addr, `I2CHS_ADDR_SAP)) begin
                slave_address_primary <= sfr_wdata;
            end else if (hit(sfr_addr, `I2CHS_ADDR_SAS)) begin
                slave_address_secondary <= sfr_wdata;
            end
        end
    end

    // byte to send on the next read transfer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte <= `I2CHS_RST_DATA;
        end else if (sfr_wr && hit(sfr_addr, `I2CHS_ADDR_DATA)) begin
            tx_byte <= sfr_wdata;
        end
    end

    // byte flag: a new byte wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_done_flag <= 1'b0;
        end else if (!slave_on) begin
            byte_done_flag <= 1'b0;
        end else if (set_flag) begin
            byte_done_flag <= 1'b1;
        end else if (data_access) begin
            byte_done_flag <= 1'b0;
        end
    end

    // remembers that this flag was already serviced
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_done <= 1'b0;
        end else if (!slave_on || set_flag) begin
            access_done <= 1'b0;
        end else if (data_access) begin
            access_done <= 1'b1;
        end
    end

    // shared vector: firmware polls both flags
    assign irq_req    = byte_done_flag | spi_flag;
    assign irq_vector = `I2CHS_VECTOR;

    // slave byte engine
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state                <= i2chs_pkg::st_idle;
            bit_cnt              <= 4'h0;
            rx_shift             <= 8'h00;
            tx_shift             <= 8'h00;
            is_addr_byte         <= 1'b0;
            host_acked           <= 1'b0;
            slave_direction_flag <= 1'b0;
        end else if (!slave_on) begin
            state   <= i2chs_pkg::st_idle;
            bit_cnt <= 4'h0;
        end else if (state == i2chs_pkg::st_halt || halt_req) begin
            state <= i2chs_pkg::st_halt;
        end else if (bus_start) begin
            state        <= i2chs_pkg::st_addr;
            bit_cnt      <= 4'h0;
            is_addr_byte <= 1'b1;
        end else if (bus_stop) begin
            state <= i2chs_pkg::st_idle;
        end else begin
            case (state)
                i2chs_pkg::st_addr, i2chs_pkg::st_rx: begin
                    if (scl_rise) begin
                        rx_shift <= {rx_shift[6:0], sda_s};
                        bit_cnt  <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `I2CHS_BYTE_BITS) begin
                        bit_cnt <= 4'h0;
                        if (!is_addr_byte) begin
                            state <= i2chs_pkg::st_push;
                        end else if (!addr_match) begin
                            state <= i2chs_pkg::st_idle;
                        end else begin
                            slave_direction_flag <= rx_shift[0];
                            // a read transfer needs no address in the fifo
                            state <= rx_shift[0] ? i2chs_pkg::st_ack : i2chs_pkg::st_push;
                        end
                    end
                end
                i2chs_pkg::st_push: begin
                    // full fifo keeps the clock stretched
                    if (fifo_in_ready) begin
                        state <= i2chs_pkg::st_ack;
                    end
                end
                i2chs_pkg::st_ack: begin
                    if (scl_fall) begin
                        state        <= i2chs_pkg::st_stretch;
                        is_addr_byte <= 1'b0;
                    end
                end
                i2chs_pkg::st_stretch: begin
                    if (!byte_done_flag) begin
                        bit_cnt  <= 4'h0;
                        tx_shift <= tx_byte;
                        state    <= slave_direction_flag ? i2chs_pkg::st_tx : i2chs_pkg::st_rx;
                    end
                end
                i2chs_pkg::st_tx: begin
                    if (scl_fall) begin
                        tx_shift <= {tx_shift[6:0], 1'b1};
                        bit_cnt  <= bit_cnt + 4'h1;
                        if (bit_cnt == `I2CHS_BYTE_BITS - 4'h1) begin
                            state <= i2chs_pkg::st_txack;
                        end
                    end
                end
                i2chs_pkg::st_txack: begin
                    if (scl_rise) begin
                        host_acked <= ~sda_s;
                    end else if (scl_fall) begin
                        // nack ends the transfer without a flag
                        state <= host_acked ? i2chs_pkg::st_stretch : i2chs_pkg::st_idle;
                    end
                end
                default: begin
                    state <= i2chs_pkg::st_idle;
                end
            endcase
        end
    end

    // registered pin drivers; pins never shared
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_data_pin_out    <= 1'b0;
            serial_data_pin_oe_n   <= 1'b1;
            serial_clock_line_out  <= 1'b0;
            serial_clock_line_oe_n <= 1'b1;
        end else if (master_select_bit) begin
            serial_data_pin_out    <= master_data_out_bit;
            serial_data_pin_oe_n   <= ~data_pin_output_enable;
            serial_clock_line_out  <= master_clock_out_bit;
            serial_clock_line_oe_n <= 1'b0;
        end else begin
            serial_data_pin_out    <= 1'b0;
            serial_data_pin_oe_n   <= ~((state == i2chs_pkg::st_push) | (state == i2chs_pkg::st_ack) |
                                        ((state == i2chs_pkg::st_tx) & ~tx_shift[7]));
            serial_clock_line_out  <= 1'b0;
            serial_clock_line_oe_n <= ~((state == i2chs_pkg::st_push) |
                                        (state == i2chs_pkg::st_stretch));
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            if (ctrl_hit) begin
                sfr_rdata <= ctrl_view;
            end else if (hit(sfr_addr, `I2CHS_ADDR_DATA)) begin
                sfr_rdata <= fifo_out_valid ? fifo_out_data : `I2CHS_RST_DATA;
            end else if (hit(sfr_addr, `I2CHS_ADDR_SAP)) begin
                sfr_rdata <= slave_address_primary;
            end else if (hit(sfr_addr, `I2CHS_ADDR_SAS)) begin
                sfr_rdata <= slave_address_secondary;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

endmodule

/* i2chs_defs.svh */
// register map, reset values and field positions of the two-wire slave/master block
// Operation
// - hardware slave plus firmware bit-level master mode
// - secondary address at F2H, resets to 7FH
// - two-wire and SPI requests share vector 3BH
// - bit 7 drives data pin only when enabled
// - bit 6 set makes data pin output, clear input
// - bit 5 appears directly on clock pin
// - master with output disabled latches data pin into bit 4
// - bit 3 selects firmware master, clear hardware slave
// - bit 2 holds slave in reset until cleared
// - slave direction bit 1 set when transmitting
// - flag bit 0 set after each acknowledged byte
// - control at E8H, resets to 00H, bit addressable
// - primary address at 9BH, resets to 55H, writable
// - interface permanently owns its pins
// - any data register access clears the flag; a flag set in the same cycle stays set
// - second data access per flag halts slave
// - slave stretches clock after address match until flag cleared
// - no flag for a NACKed byte; slave returns idle
`ifndef I2CHS_DEFS_SVH
`define I2CHS_DEFS_SVH

`define I2CHS_ADDR_CTRL 8'he8
`define I2CHS_ADDR_DATA 8'h9a
`define I2CHS_ADDR_SAP  8'h9b
`define I2CHS_ADDR_SAS  8'hf2

`define I2CHS_RST_CTRL  8'h00
`define I2CHS_RST_DATA  8'h00
`define I2CHS_RST_SAP   8'h55
`define I2CHS_RST_SAS   8'h7f

`define I2CHS_VECTOR    8'h3b

`define I2CHS_B_MDO     7
`define I2CHS_B_MDE     6
`define I2CHS_B_MCO     5
`define I2CHS_B_MDI     4
`define I2CHS_B_MSEL    3
`define I2CHS_B_SRST    2
`define I2CHS_B_DIR     1
`define I2CHS_B_FLAG    0

`define I2CHS_FIFO_DEPTH 4
`define I2CHS_BYTE_BITS  4'h8

`endif

/* i2chs_pkg.sv */
// types shared by the two-wire slave/master block
package i2chs_pkg;
    typedef enum logic [3:0] {
        st_idle, st_addr, st_push, st_ack, st_stretch,
        st_rx, st_tx, st_txack, st_halt
    } i2chs_state_e;
endpackage

/* i2chs_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module i2chs_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= '1;
            sync_out <= '1;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* i2chs_fifo.sv */
// small receive fifo with valid/ready on both sides
`timescale 1ns/10ps
module i2chs_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wp;
    logic [AW:0]  rp;

    // full when pointers differ only in the wrap bit
    assign in_ready  = (wp[AW] == rp[AW]) || (wp[AW-1:0] != rp[AW-1:0]);
    assign out_valid = (wp != rp);
    assign out_data  = mem[rp[AW-1:0]];

    // storage, no reset needed
    always_ff @(posedge ref_clk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wp <= wp + 1'b1;
            end
            if (out_valid && out_ready) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule

/* i2chs_props.sv */
// port-level assertions for the two-wire slave/master block
`timescale 1ns/10ps
module i2chs_props (
    input logic       ref_clk,
    input logic       rst_n,
    input logic [7:0] sfr_addr,
    input logic       sfr_wr,
    input logic       sfr_rd,
    input logic [7:0] sfr_wdata,
    input logic       sfr_bit_wr,
    input logic [2:0] sfr_bit_sel,
    input logic       sfr_bit_val,
    input logic [7:0] sfr_rdata,
    input logic       spi_flag,
    input logic       irq_req,
    input logic [7:0] irq_vector,
    input logic       serial_data_pin_out,
    input logic       serial_data_pin_oe_n,
    input logic       serial_clock_line_out,
    input logic       serial_clock_line_oe_n
);
    logic [7:0] ctl;
    logic [7:0] sap;
    logic [7:0] sas;
    logic [2:0] rs_cnt;
    // own copy of control bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) ctl <= 8'h00;
        else if (sfr_wr && sfr_addr == 8'he8) ctl <= sfr_wdata;
        else if (sfr_bit_wr && sfr_addr == 8'he8) ctl[sfr_bit_sel] <= sfr_bit_val;
    end
    // own copies of both address registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sap <= 8'h55;
            sas <= 8'h7f;
        end else if (sfr_wr) begin
            if (sfr_addr == 8'h9b) sap <= sfr_wdata;
            if (sfr_addr == 8'hf2) sas <= sfr_wdata;
        end
    end
    // cycles held in slave reset; registered pins need settling
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) rs_cnt <= 3'h0;
        else if (!ctl[2] || ctl[3]) rs_cnt <= 3'h0;
        else if (rs_cnt != 3'h7) rs_cnt <= rs_cnt + 3'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_vector_const: assert property (irq_vector == 8'h3b) else $error("vector wrong");
    a_spi_shared: assert property (spi_flag |-> irq_req) else $error("spi request lost");
    a_master_clock: assert property (ctl[3] && $stable(ctl) |->
        serial_clock_line_out == ctl[5] && !serial_clock_line_oe_n) else $error("clock pin wrong");
    a_master_drive: assert property (ctl[3] && ctl[6] && $stable(ctl) |->
        !serial_data_pin_oe_n && serial_data_pin_out == ctl[7]) else $error("data drive wrong");
    a_master_listen: assert property (ctl[3] && !ctl[6] && $stable(ctl) |->
        serial_data_pin_oe_n) else $error("data pin driven");
    a_reset_quiet: assert property (rs_cnt == 3'h7 |->
        serial_data_pin_oe_n && serial_clock_line_oe_n) else $error("pins busy in reset");
    a_slave_low_only: assert property (!ctl[3] && $stable(ctl) && !serial_data_pin_oe_n |->
        !serial_data_pin_out) else $error("slave drives high");
    a_unmapped_zero: assert property (sfr_rd && !(sfr_addr inside {8'he8, 8'h9a, 8'h9b, 8'hf2})
        |=> sfr_rdata == 8'h00) else $error("unmapped read nonzero");
    a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
    a_addr_store: assert property (sfr_rd && sfr_addr == 8'h9b |=> sfr_rdata == sap)
        else $error("primary address wrong");
    a_addr2_store: assert property (sfr_rd && sfr_addr == 8'hf2 |=> sfr_rdata == sas)
        else $error("secondary address wrong");
    c_master: cover property (ctl[3] && ctl[6] && $stable(ctl));
    c_held_reset: cover property (rs_cnt == 3'h7);
    c_stretch: cover property (!ctl[3] && !serial_clock_line_oe_n);
endmodule
bind i2chs_top i2chs_props chk (.*);

/* i2chs_bus_host.sv */
// two-wire bus master model, open-drain against pull-ups, 48 ns bit clock
`timescale 1ns/10ps
module i2chs_bus_host (
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_pull,
    output logic      sda_pull,
    output logic      stuck
);
    initial begin
        scl_pull = 0;
        sda_pull = 0;
        stuck = 0;
    end
    // release clock; the slave may stretch it, so the wait is bounded
    task rise();
        int k;
        k = 0;
        scl_pull = 0;
        while (!scl_line && k < 400) begin
            #5;
            k++;
        end
        if (!scl_line) stuck = 1;
        #12;
    endtask
    task start();
        sda_pull = 1;
        #24;
        scl_pull = 1;
    endtask
    task stop();
        #12;
        sda_pull = 1;
        #12;
        rise();
        #12;
        sda_pull = 0;
        #24;
    endtask
    // msb first; ack is 1 when the slave pulled data low in the ninth clock
    task wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #12;
            sda_pull = !b[i];
            #12;
            rise();
            #12;
            scl_pull = 1;
        end
        #12;
        sda_pull = 0;
        #12;
        rise();
        ack = !sda_line;
        #12;
        scl_pull = 1;
    endtask
    task rbyte(output logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) begin
            #24;
            rise();
            b[i] = sda_line;
            #12;
            scl_pull = 1;
        end
        #12;
        sda_pull = !nack;
        #12;
        rise();
        #12;
        scl_pull = 1;
        #12;
        sda_pull = 0;
    endtask
endmodule

/* tb.sv */
// testbench: registers, slave transfers and firmware master mode
`timescale 1ns/10ps
`include "i2chs_defs.svh"
module tb;
    logic       ref_clk, rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, spi_flag;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, irq_vector, d;
    logic [2:0] sfr_bit_sel;
    logic       irq_req, sda_out, sda_oe_n, scl_out, scl_oe_n, scl_pull, sda_pull, stuck, a;
    wire        scl_w = (scl_oe_n | scl_out) & !scl_pull;
    wire        sda_w = (sda_oe_n | sda_out) & !sda_pull;
    int         n_errors, n_checks;
    i2chs_top dut (.*, .serial_data_pin_in(sda_w), .serial_data_pin_out(sda_out), .serial_data_pin_oe_n(sda_oe_n),
        .serial_clock_line_in(scl_w), .serial_clock_line_out(scl_out), .serial_clock_line_oe_n(scl_oe_n));
    i2chs_bus_host host (.scl_line(scl_w), .sda_line(sda_w), .*);
    initial begin
        ref_clk = 0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task final_report();
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t bit %b want %b", $time, got, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] v);
        @(negedge ref_clk);
        sfr_addr = ad;
        sfr_wdata = v;
        sfr_wr = 1;
        @(negedge ref_clk);
        sfr_wr = 0;
    endtask
    task rd(input logic [7:0] ad, input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = ad;
        sfr_rd = 1;
        @(negedge ref_clk);
        sfr_rd = 0;
        @(negedge ref_clk);
        chk8(sfr_rdata, exp);
    endtask
    task bwr(input logic [2:0] sel, input logic v);
        @(negedge ref_clk);
        sfr_addr = `I2CHS_ADDR_CTRL;
        sfr_bit_sel = sel;
        sfr_bit_val = v;
        sfr_bit_wr = 1;
        @(negedge ref_clk);
        sfr_bit_wr = 0;
    endtask
    // flag follows ack clock after sync delay
    task wait_irq();
        int k;
        k = 0;
        while (irq_req !== 1'b1 && k < 200) begin
            @(negedge ref_clk);
            k++;
        end
        chk1(irq_req, 1'b1);
        if (irq_req !== 1'b1) final_report();
    endtask
    // a host that never sees its clock released ends the run
    always @(posedge stuck) begin
        n_errors++;
        $display("FAIL %0t bus clock held", $time);
        final_report();
    end
    initial begin
        {rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, spi_flag} = 6'h00;
        {sfr_addr, sfr_wdata, sfr_bit_sel} = 19'h00000;
        n_errors = 0;
        n_checks = 0;
        idle(20);
        rst_n = 1;
        rd(`I2CHS_ADDR_CTRL, 8'h00);
        rd(`I2CHS_ADDR_SAP, 8'h55);
        rd(`I2CHS_ADDR_SAS, 8'h7f);
        rd(`I2CHS_ADDR_DATA, 8'h00);
        rd(8'h10, 8'h00);
        chk8(irq_vector, 8'h3b);
        wr(`I2CHS_ADDR_CTRL, 8'h13);
        rd(`I2CHS_ADDR_CTRL, 8'h00);
        spi_flag = 1;
        idle(1);
        chk1(irq_req, 1'b1);
        spi_flag = 0;
        // slave receive: address then one data byte
        host.start();
        host.wbyte(8'haa, a);
        chk1(a, 1'b1);
        wait_irq();
        idle(4);
        chk1(scl_oe_n, 1'b0);
        rd(`I2CHS_ADDR_CTRL, 8'h01);
        rd(`I2CHS_ADDR_DATA, 8'haa);
        idle(4);
        chk1(irq_req, 1'b0);
        chk1(scl_oe_n, 1'b1);
        host.wbyte(8'h3c, a);
        chk1(a, 1'b1);
        wait_irq();
        rd(`I2CHS_ADDR_DATA, 8'h3c);
        host.stop();
        // new addresses: both read back, old primary no longer answers
        wr(`I2CHS_ADDR_SAP, 8'h12);
        wr(`I2CHS_ADDR_SAS, 8'h21);
        rd(`I2CHS_ADDR_SAP, 8'h12);
        rd(`I2CHS_ADDR_SAS, 8'h21);
        host.start();
        host.wbyte(8'haa, a);
        chk1(a, 1'b0);
        idle(20);
        chk1(irq_req, 1'b0);
        host.stop();
        // slave transmit, ended by a nack
        host.start();
        host.wbyte(8'h43, a);
        chk1(a, 1'b1);
        wait_irq();
        rd(`I2CHS_ADDR_CTRL, 8'h03);
        wr(`I2CHS_ADDR_DATA, 8'ha5);
        host.rbyte(d, 1'b1);
        chk8(d, 8'ha5);
        idle(20);
        chk1(irq_req, 1'b0);
        host.stop();
        // second data access halts slave until reset bit cycles
        host.start();
        host.wbyte(8'h42, a);
        wait_irq();
        rd(`I2CHS_ADDR_DATA, 8'h42);
        wr(`I2CHS_ADDR_DATA, 8'h00);
        host.stop();
        host.start();
        host.wbyte(8'h42, a);
        chk1(a, 1'b0);
        host.stop();
        bwr(3'h2, 1'b1);
        idle(10);
        bwr(3'h2, 1'b0);
        rd(`I2CHS_ADDR_CTRL, 8'h00);
        host.start();
        host.wbyte(8'h24, a);
        chk1(a, 1'b1);
        wait_irq();
        rd(`I2CHS_ADDR_DATA, 8'h24);
        host.stop();
        // firmware master: pins follow the control bits
        wr(`I2CHS_ADDR_CTRL, 8'he8);
        idle(2);
        chk1(sda_out, 1'b1);
        chk1(sda_oe_n, 1'b0);
        chk1(scl_out, 1'b1);
        chk1(scl_oe_n, 1'b0);
        bwr(3'h7, 1'b0);
        idle(2);
        chk1(sda_out, 1'b0);
        wr(`I2CHS_ADDR_CTRL, 8'h08);
        idle(2);
        chk1(sda_oe_n, 1'b1);
        chk1(scl_out, 1'b0);
        host.sda_pull = 1;
        wr(`I2CHS_ADDR_CTRL, 8'h28);
        idle(8);
        rd(`I2CHS_ADDR_CTRL, 8'h28);
        host.sda_pull = 0;
        wr(`I2CHS_ADDR_CTRL, 8'h08);
        idle(8);
        wr(`I2CHS_ADDR_CTRL, 8'h28);
        idle(8);
        rd(`I2CHS_ADDR_CTRL, 8'h38);
        wr(`I2CHS_ADDR_CTRL, 8'h00);
        idle(4);
        final_report();
    end
endmodule
